// [verilog/rct_consts.svh]
// Constants of the rolling code transmitter: offsets, field positions,
// reset values and timing figures.
// Assumes a 25 MHz system clock.
`ifndef RCT_CONSTS_SVH
`define RCT_CONSTS_SVH

`define RCT_CLK_MHZ       25
`define RCT_DEBOUNCE_US   9000
`define RCT_TE_SLOW_US    340
`define RCT_TE_FAST_US    170

`define RCT_PRE_END       9'd23
`define RCT_HDR_END       9'd33
`define RCT_DATA_END      9'd228
`define RCT_WORD_SLOW     9'd234
`define RCT_WORD_FAST     9'd468
`define RCT_CIPHER_ROUNDS 64

`define RCT_ADR_CTRL      8'h00
`define RCT_ADR_SERIAL    8'h04
`define RCT_ADR_KEY_LO    8'h08
`define RCT_ADR_KEY_HI    8'h0c
`define RCT_ADR_SYNC      8'h10
`define RCT_ADR_STATUS    8'h14

`define RCT_CTRL_FAST     0
`define RCT_SYNC_OVF      16

`define RCT_FAST_RST      1'b0
`define RCT_SERIAL_RST    28'h0000000
`define RCT_KEY_RST       64'h0000000000000000
`define RCT_SYNC_RST      16'h0000

`endif

// [verilog/rct_pkg.sv]
// Types shared by the rolling code transmitter modules.
// Assumes nothing of its surroundings.
package rct_pkg;

  typedef enum logic [1:0] {RCT_IDLE, RCT_DEBOUNCE, RCT_CIPHER, RCT_SEND} rct_state_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } rct_wb_req_t;

  typedef struct packed {
    logic [23:0] cnt;
    logic [2:0]  last;
    logic        valid;
  } rct_db_st_t;

  typedef struct packed {
    logic        busy;
    logic        done;
    logic [6:0]  rnd;
    logic [31:0] x;
  } rct_ciph_st_t;

  typedef struct packed {
    rct_state_t  st;
    logic        fast;
    logic [27:0] serial;
    logic [63:0] key;
    logic [15:0] sync;
    logic        ovf;
    logic [2:0]  func;
    logic [64:0] word;
    logic [15:0] tmr;
    logic [8:0]  e;
    logic [1:0]  ph;
    logic [6:0]  bi;
    logic        pwm;
    logic        txa;
    logic        ack;
    logic [31:0] rdat;
    logic        cstart;
    logic        dbrst;
  } rct_top_st_t;

endpackage

// [verilog/rct_debounce.sv]
// Debounce filter for the three button lines.
// Assumes synchronous inputs; restart_i clears the settled flag.
`timescale 1ns/10ps
`default_nettype none
module rct_debounce
  import rct_pkg::*;
#(
  parameter int unsigned CYC = 225000
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       restart_i,
  input  wire logic [2:0] raw_i,
  output logic      [2:0] level_o,
  output logic            valid_o
);

  rct_db_st_t cur;
  rct_db_st_t nxt;

  // ---------------------------------------------------------------
  // Settling counter
  // ---------------------------------------------------------------
  // The lines must hold one value for the whole interval.
  always_comb begin
    nxt = cur;
    if (restart_i || raw_i != cur.last) begin
      nxt.cnt   = 24'h0;
      nxt.valid = 1'b0;
      nxt.last  = raw_i;
    end else if (cur.cnt == 24'(CYC - 1)) begin
      nxt.valid = 1'b1;
    end else begin
      nxt.cnt = cur.cnt + 24'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  assign level_o = cur.last;
  assign valid_o = cur.valid;

  a_settle_span: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(cur.valid) |-> $past(cur.cnt) == 24'(CYC - 1) && $stable(cur.last))
    else $error("settled flag rose before the full interval");

endmodule
`default_nettype wire

// [verilog/rct_cipher.sv]
// Keyed nonlinear shift cipher that turns the rolling plaintext into code.
// Assumes start_i is a one-cycle pulse with plain_i and key_i stable.
`timescale 1ns/10ps
`default_nettype none
`include "rct_consts.svh"
module rct_cipher
  import rct_pkg::*;
#(
  parameter int unsigned ROUNDS = `RCT_CIPHER_ROUNDS
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        start_i,
  input  wire logic [31:0] plain_i,
  input  wire logic [63:0] key_i,
  output logic             done_o,
  output logic      [31:0] code_o
);

  rct_ciph_st_t cur;
  rct_ciph_st_t nxt;
  logic         fb;

  // ---------------------------------------------------------------
  // Round engine
  // ---------------------------------------------------------------
  // One key bit is mixed in per round; the key is never copied out.
  always_comb begin
    nxt      = cur;
    nxt.done = 1'b0;
    fb = cur.x[0] ^ cur.x[9] ^ cur.x[31] ^ (cur.x[26] & cur.x[20])
       ^ (cur.x[1] & ~cur.x[16]) ^ key_i[cur.rnd[5:0]];
    if (start_i) begin
      nxt.busy = 1'b1;
      nxt.rnd  = 7'h0;
      nxt.x    = plain_i;
    end else if (cur.busy) begin
      nxt.x   = {fb, cur.x[31:1]};
      nxt.rnd = cur.rnd + 7'h1;
      if (cur.rnd == 7'(ROUNDS - 1)) begin
        nxt.busy = 1'b0;
        nxt.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  assign done_o = cur.done;
  assign code_o = cur.x;

  a_cipher_bound: assert property (@(posedge clk_i) disable iff (rst_i)
    start_i |-> ##[1:130] cur.done)
    else $error("cipher did not finish in time");

endmodule
`default_nettype wire

// [verilog/rct_top.sv]
// Rolling code button transmitter: debounce, code word build and
// pulse-width output sequencer with a classic Wishbone register slave.
// Assumes button lines and lowbat_i are synchronous to clk_i.
//
// Overview of operation
// - Any press starts a debounce wait first.
// - Debounced lines form function code; zero idles.
// - Repeat the word while any line held.
// - New press aborts word and restarts debounce.
// - Partial release keeps the function code.
// - Full release still completes the current word.
// - Fast rate blanks every other word slot.
// - Word: 32 rolling, 28 serial, 3 function, battery, overflow.
// - Rolling part encrypted with stored secret key.
// - Key is write only, never read back.
// - Store serial, key and rate setting.
// - Overflow flag set after full counter cycle.
// - Rolling value not reused within 65536 presses.
// - Battery bit is one when supply low.
// - Bit is three elements; one or two high.
// - Word period 234 slow, 468 fast elements.
`timescale 1ns/10ps
`default_nettype none
`include "rct_consts.svh"
module rct_top
  import rct_pkg::*;
#(
  parameter int unsigned DB_CYC      = `RCT_DEBOUNCE_US * `RCT_CLK_MHZ,
  parameter int unsigned TE_SLOW_CYC = `RCT_TE_SLOW_US * `RCT_CLK_MHZ,
  parameter int unsigned TE_FAST_CYC = `RCT_TE_FAST_US * `RCT_CLK_MHZ
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [2:0]  button_lines_i,
  input  wire logic        lowbat_i,
  input  wire rct_wb_req_t wb_req_i,
  output logic             wb_ack_o,
  output logic      [31:0] wb_dat_o,
  output logic             pwm_o,
  output logic             tx_active_o
);

  rct_top_st_t cur;
  rct_top_st_t nxt;
  logic [2:0]  db_level;
  logic        db_valid;
  logic        ciph_done;
  logic [31:0] ciph_code;
  logic [15:0] te_cyc;
  logic [8:0]  period;
  logic        tick;
  logic        press;
  logic        take;
  logic        wr;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] wb_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Output level of one element; guard and blanked slot stay low.
  function automatic logic elem_level(input logic [8:0]  e,
                                      input logic [1:0]  ph,
                                      input logic [6:0]  bi,
                                      input logic [64:0] word);
    logic r;
    r = 1'b0;
    if (e < `RCT_PRE_END) begin
      r = ~e[0];
    end else if (e >= `RCT_HDR_END && e < `RCT_DATA_END) begin
      r = (ph == 2'd0) || (ph == 2'd1 && !word[bi]);
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------
  rct_debounce #(.CYC(DB_CYC)) u_db (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .restart_i (cur.dbrst),
    .raw_i     (button_lines_i),
    .level_o   (db_level),
    .valid_o   (db_valid)
  );

  rct_cipher u_ciph (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (cur.cstart),
    .plain_i ({cur.ovf, cur.func, cur.serial[11:0], cur.sync}),
    .key_i   (cur.key),
    .done_o  (ciph_done),
    .code_o  (ciph_code)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  assign te_cyc = cur.fast ? 16'(TE_FAST_CYC) : 16'(TE_SLOW_CYC);
  assign period = cur.fast ? `RCT_WORD_FAST : `RCT_WORD_SLOW;
  assign tick   = cur.tmr == te_cyc - 16'h1;
  assign press  = |(button_lines_i & ~cur.func);
  assign take   = cur.st == RCT_DEBOUNCE && db_valid && !cur.dbrst;
  assign wr     = cur.ack && wb_req_i.cyc && wb_req_i.stb && wb_req_i.we;

  always_comb begin
    logic [31:0] m;
    m          = 32'h0;
    nxt        = cur;
    nxt.ack    = 1'b0;
    nxt.cstart = 1'b0;
    nxt.dbrst  = 1'b0;
    if (wb_req_i.cyc && wb_req_i.stb && !cur.ack) begin
      nxt.ack = 1'b1;
      case (wb_req_i.adr)
        `RCT_ADR_CTRL:   nxt.rdat = {31'h0, cur.fast};
        `RCT_ADR_SERIAL: nxt.rdat = {4'h0, cur.serial};
        `RCT_ADR_SYNC:   nxt.rdat = {15'h0, cur.ovf, cur.sync};
        `RCT_ADR_STATUS: nxt.rdat = {26'h0, cur.txa, cur.func, cur.st};
        default:         nxt.rdat = 32'h0;
      endcase
    end
    if (wr) begin
      case (wb_req_i.adr)
        `RCT_ADR_CTRL: begin
          m = wb_merge({31'h0, cur.fast}, wb_req_i.dat, wb_req_i.sel);
          nxt.fast = m[`RCT_CTRL_FAST];
        end
        `RCT_ADR_SERIAL: begin
          m = wb_merge({4'h0, cur.serial}, wb_req_i.dat, wb_req_i.sel);
          nxt.serial = m[27:0];
        end
        `RCT_ADR_KEY_LO: begin
          nxt.key[31:0] = wb_merge(cur.key[31:0], wb_req_i.dat, wb_req_i.sel);
        end
        `RCT_ADR_KEY_HI: begin
          nxt.key[63:32] = wb_merge(cur.key[63:32], wb_req_i.dat, wb_req_i.sel);
        end
        `RCT_ADR_SYNC: begin
          m = wb_merge({15'h0, cur.ovf, cur.sync}, wb_req_i.dat, wb_req_i.sel);
          nxt.sync = m[15:0];
          nxt.ovf  = m[`RCT_SYNC_OVF];
        end
        default: begin
          m = 32'h0;
        end
      endcase
    end
    case (cur.st)
      RCT_IDLE: begin
        if (|button_lines_i) begin
          nxt.st    = RCT_DEBOUNCE;
          nxt.dbrst = 1'b1;
        end
      end
      RCT_DEBOUNCE: begin
        if (take) begin
          nxt.func = db_level;
          if (db_level == 3'h0) begin
            nxt.st = RCT_IDLE;
          end else begin
            nxt.st     = RCT_CIPHER;
            nxt.cstart = 1'b1;
            nxt.sync   = cur.sync + 16'h1;
            if (&cur.sync) begin
              nxt.ovf = 1'b1;
            end
          end
        end
      end
      RCT_CIPHER: begin
        if (ciph_done) begin
          nxt.word = {ciph_code, cur.ovf, lowbat_i, cur.func, cur.serial};
          nxt.st   = RCT_SEND;
          nxt.tmr  = 16'h0;
          nxt.e    = 9'h0;
          nxt.ph   = 2'd0;
          nxt.bi   = 7'h0;
        end
      end
      RCT_SEND: begin
        if (press) begin
          nxt.st    = RCT_DEBOUNCE;
          nxt.dbrst = 1'b1;
        end else if (tick) begin
          nxt.tmr = 16'h0;
          if (cur.e == period - 9'h1) begin
            nxt.e  = 9'h0;
            nxt.ph = 2'd0;
            nxt.bi = 7'h0;
            if (button_lines_i == 3'h0) begin
              nxt.st = RCT_IDLE;
            end
          end else begin
            nxt.e = cur.e + 9'h1;
            if (cur.e < `RCT_HDR_END) begin
              nxt.ph = 2'd0;
              nxt.bi = 7'h0;
            end else if (cur.ph == 2'd2) begin
              nxt.ph = 2'd0;
              nxt.bi = cur.bi + 7'h1;
            end else begin
              nxt.ph = cur.ph + 2'd1;
            end
          end
        end else begin
          nxt.tmr = cur.tmr + 16'h1;
        end
      end
      default: begin
        nxt.st = RCT_IDLE;
      end
    endcase
    nxt.txa = nxt.st == RCT_SEND;
    nxt.pwm = nxt.txa && elem_level(nxt.e, nxt.ph, nxt.bi, nxt.word);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur        <= '0;
      cur.st     <= RCT_IDLE;
      cur.fast   <= `RCT_FAST_RST;
      cur.serial <= `RCT_SERIAL_RST;
      cur.key    <= `RCT_KEY_RST;
      cur.sync   <= `RCT_SYNC_RST;
    end else begin
      cur <= nxt;
    end
  end

  assign wb_ack_o    = cur.ack;
  assign wb_dat_o    = cur.rdat;
  assign pwm_o       = cur.pwm;
  assign tx_active_o = cur.txa;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_press_seen;
    cur.st == RCT_SEND && press;
  endsequence
  sequence s_rearm;
    cur.st == RCT_DEBOUNCE && cur.dbrst;
  endsequence
  sequence s_word_end;
    cur.st == RCT_SEND && !press && tick && cur.e == period - 9'h1;
  endsequence

  a_debounce_gate: assert property (
    $rose(cur.st == RCT_CIPHER) |-> $past(take)) else $error("code taken before debounce");
  a_func_sample: assert property (
    take |=> cur.func == $past(db_level) && (cur.st == RCT_IDLE) == (cur.func == 3'h0))
    else $error("function code not sampled");
  a_repeat_word: assert property (
    s_word_end ##0 (button_lines_i != 3'h0) |=> cur.st == RCT_SEND && cur.e == 9'h0)
    else $error("word not repeated");
  a_restart_press: assert property (
    s_press_seen |=> s_rearm ##1 (cur.st == RCT_DEBOUNCE && !pwm_o))
    else $error("new press did not restart");
  a_func_held: assert property (
    (cur.st == RCT_SEND && !press) |=> $stable(cur.func)) else $error("code changed");
  a_finish_word: assert property (
    (cur.st == RCT_SEND && !press && !(tick && cur.e == period - 9'h1)) |=> cur.st == RCT_SEND)
    else $error("word cut short");
  a_blank_slot: assert property (
    (cur.st == RCT_SEND && cur.e >= `RCT_WORD_SLOW) |-> cur.fast && !pwm_o)
    else $error("blank slot not silent");
  a_word_layout: assert property (
    (cur.st == RCT_CIPHER && ciph_done) |=>
      cur.word[64:33] == $past(ciph_code) && cur.word[27:0] == cur.serial
      && cur.word[30:28] == cur.func && cur.word[31] == $past(lowbat_i))
    else $error("code word fields misplaced");
  a_key_hidden: assert property (
    (wb_req_i.cyc && wb_req_i.stb && !cur.ack && (wb_req_i.adr == `RCT_ADR_KEY_LO
      || wb_req_i.adr == `RCT_ADR_KEY_HI)) |=> wb_ack_o && wb_dat_o == 32'h0)
    else $error("key readable");
  a_ovf_wrap: assert property (
    (take && db_level != 3'h0 && &cur.sync) |=> cur.ovf && cur.sync == 16'h0)
    else $error("overflow not flagged");
  a_sync_adv: assert property (
    (take && db_level != 3'h0 && !wr) |=> cur.sync == $past(cur.sync) + 16'h1)
    else $error("sync counter not advanced");
  a_bit_shape: assert property (
    (cur.st == RCT_SEND && cur.e >= `RCT_HDR_END && cur.e < `RCT_DATA_END) |->
      pwm_o == (cur.ph == 2'd0 || (cur.ph == 2'd1 && !cur.word[cur.bi])))
    else $error("bit shape wrong");
  a_preamble: assert property (
    (cur.st == RCT_SEND && cur.e < `RCT_HDR_END) |-> pwm_o == (cur.e < `RCT_PRE_END && !cur.e[0])
      && cur.e < period) else $error("preamble or header wrong");

endmodule
`default_nettype wire

// [dv/rct_rx_model.sv]
// Receiver model that decodes the pulse-width coded word from the output line.
// Assumes te_i gives the element length in clock cycles and pwm_i is registered.
`timescale 1ns/10ps
`default_nettype none
module rct_rx_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        pwm_i,
  input  wire logic [15:0] te_i,
  output var  logic [64:0] word_o,
  output var  int          words_o,
  output var  int          bad_o,
  output var  int          period_o
);
  int          c;
  int          e;
  int          lowrun;
  int          since;
  logic        busy;
  logic        fault;
  logic [64:0] w;
  // ----------------------------------------------------------------
  // Frame decoder
  // ----------------------------------------------------------------
  // A frame starts at the first high element; a low run longer than the header
  // means the word was abandoned, and that frame is dropped without a verdict.
  always @(posedge clk_i) begin
    if (rst_i) begin
      busy = 1'b0;
      words_o = 0;
      bad_o = 0;
      period_o = 0;
      since = 0;
      lowrun = 0;
    end else begin
      since++;
      lowrun = pwm_i ? 0 : lowrun + 1;
      if (!busy && pwm_i) begin
        busy = 1'b1;
        c = 0;
        fault = 1'b0;
        period_o = since;
        since = 0;
      end
      if (busy) begin
        if (c % te_i == te_i / 2) begin
          e = c / te_i;
          if (e < 23) begin
            fault = fault | (pwm_i !== ~e[0]);
          end else if (e < 33) begin
            fault = fault | pwm_i;
          end else if ((e - 33) % 3 == 1) begin
            w[(e - 33) / 3] = ~pwm_i;
          end else begin
            fault = fault | (pwm_i !== ((e - 33) % 3 == 0));
          end
        end
        c++;
        if (lowrun > 11 * te_i) begin
          busy = 1'b0;
        end else if (c == 228 * te_i) begin
          busy = 1'b0;
          words_o++;
          bad_o = bad_o + fault;
          word_o = w;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [dv/testbench.sv]
// Self-checking bench for the rolling code transmitter top.
// Assumes the receiver model decodes the output line and short sim timings.
`timescale 1ns/10ps
`default_nettype none
`include "rct_consts.svh"
module testbench
  import rct_pkg::*;
;
  logic        clk;
  logic        rst;
  logic [2:0]  btn;
  logic        lowbat;
  rct_wb_req_t wb_req;
  logic        ack;
  logic [31:0] dat;
  logic        pwm;
  logic        txa;
  logic [15:0] te;
  logic [64:0] rx_word;
  int          words;
  int          bad;
  int          period;
  int          error_cnt;
  int          check_count;
  logic [31:0] q;
  logic [31:0] prev;
  logic [64:0] first;
  int          n;

  rct_top #(.DB_CYC(20), .TE_SLOW_CYC(4), .TE_FAST_CYC(2)) dut (
    .clk_i(clk), .rst_i(rst), .button_lines_i(btn), .lowbat_i(lowbat), .wb_req_i(wb_req),
    .wb_ack_o(ack), .wb_dat_o(dat), .pwm_o(pwm), .tx_active_o(txa));
  rct_rx_model rx (
    .clk_i(clk), .rst_i(rst), .pwm_i(pwm), .te_i(te), .word_o(rx_word),
    .words_o(words), .bad_o(bad), .period_o(period));

  always #20 clk = ~clk;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [64:0] seen, input logic [64:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wb_io(input logic [7:0] a, input logic we, input logic [31:0] d);
    int k;
    @(posedge clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    q = dat;
    wb_req <= '0;
    check("wb_ack", k < 50, 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    wb_io(a, 1'b0, 32'h0);
    check(nm, q, exp);
  endtask

  task automatic press(input logic [2:0] v);
    @(posedge clk);
    btn <= v;
  endtask

  task automatic wait_word();
    int k;
    k = words;
    for (int i = 0; i < 20000 && words == k; i++) @(negedge clk);
    check("word_arrived", words != k, 1'b1);
  endtask

  task automatic wait_tx(input logic lvl);
    for (int i = 0; i < 3000 && txa !== lvl; i++) @(negedge clk);
    check("tx_active", txa, lvl);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    btn = 3'h0;
    lowbat = 1'b0;
    wb_req = '0;
    te = 16'h0004;
    error_cnt = 0;
    check_count = 0;
    prev = 32'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(`RCT_ADR_CTRL, 32'h0, "ctrl_rst");
    rd(`RCT_ADR_SYNC, 32'h0, "sync_rst");
    rd(`RCT_ADR_STATUS, 32'h0, "status_rst");
    wb_io(`RCT_ADR_SERIAL, 1'b1, 32'hfabcdef1);
    rd(`RCT_ADR_SERIAL, 32'h0abcdef1, "serial");
    wb_io(`RCT_ADR_KEY_LO, 1'b1, 32'h12345678);
    wb_io(`RCT_ADR_KEY_HI, 1'b1, 32'h9abcdef0);
    rd(`RCT_ADR_KEY_LO, 32'h0, "key_lo");
    rd(`RCT_ADR_KEY_HI, 32'h0, "key_hi");
    rd(8'h20, 32'h0, "unmapped");
    $display("test registers done");

    for (int f = 1; f < 8; f++) begin
      press(f[2:0]);
      lowbat <= f[0];
      wb_io(`RCT_ADR_STATUS, 1'b0, 32'h0);
      check("debounce_state", q[1:0], 2'h1);
      wait_word();
      first = rx_word;
      check("serial_bits", rx_word[27:0], 28'habcdef1);
      check("func_bits", rx_word[30:28], f[2:0]);
      check("lowbat_bit", rx_word[31], f[0]);
      check("ovf_bit", rx_word[32], 1'b0);
      check("rolling_new", rx_word[64:33] == prev, 1'b0);
      rd(`RCT_ADR_SYNC, f, "sync_count");
      press((f > 4) ? 3'b100 : f[2:0]);
      wait_word();
      check("repeat_word", rx_word, first);
      check("slow_period", period, 234 * 4);
      prev = rx_word[64:33];
      press(3'h0);
      wait_tx(1'b0);
    end
    $display("test functions done");

    press(3'b010);
    wait_tx(1'b1);
    repeat (400) @(posedge clk);
    n = words;
    press(3'h0);
    wait_word();
    wait_tx(1'b0);
    repeat (1500) @(posedge clk);
    check("no_more_words", words, n + 1);
    // The last function code stays visible in the status word while idle.
    rd(`RCT_ADR_STATUS, 32'h8, "idle_after_release");
    $display("test release done");

    // A press released inside the debounce interval settles on code zero.
    press(3'b001);
    repeat (5) @(posedge clk);
    press(3'h0);
    repeat (60) @(posedge clk);
    rd(`RCT_ADR_STATUS, 32'h0, "bounce_idle");
    check("bounce_no_word", words, n + 1);
    $display("test bounce done");

    press(3'b001);
    wait_tx(1'b1);
    repeat (200) @(posedge clk);
    press(3'b011);
    wb_io(`RCT_ADR_STATUS, 1'b0, 32'h0);
    check("restart_debounce", q[1:0], 2'h1);
    wait_word();
    check("new_func", rx_word[30:28], 3'h3);
    press(3'h0);
    wait_tx(1'b0);
    $display("test abort done");

    wb_io(`RCT_ADR_CTRL, 1'b1, 32'h1);
    rd(`RCT_ADR_CTRL, 32'h1, "ctrl_fast");
    te <= 16'h0002;
    wb_io(`RCT_ADR_SYNC, 1'b1, 32'hffff);
    lowbat <= 1'b0;
    press(3'b110);
    wait_word();
    check("ovf_set", rx_word[32], 1'b1);
    check("func_fast", rx_word[31:28], 4'h6);
    rd(`RCT_ADR_SYNC, 32'h10000, "sync_wrap");
    wait_word();
    check("fast_period", period, 468 * 2);
    press(3'h0);
    wait_tx(1'b0);
    check("frame_faults", bad, 0);
    $display("test fast rate done");
    final_report();
  end

  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    final_report();
  end
endmodule
`default_nettype wire
